// ### gfs_syndrome_regs.v
// global fault syndrome register bank with banked secure and non-secure copies
// assumes an AHB-Lite master with single word transfers, one sideband bit telling
// the security of each access, and a fault source that pulses one report per fault
//
// Contract
// - separate non-secure and secure first syndrome copies, chosen by access security
// - bit 6 marks faults from a stage-one context-bank translation operation; the secure copy masks it to zero
// - bit 5 records non-secure attribute; reserved in the non-secure copy
// - bit 4 records non-secure device state; reserved in the non-secure copy
// - non-secure client faults reported to secure status set the state bit
// - non-secure config access to secure-only resource reports in secure copy
// - with external-fault control set, non-secure external abort goes to secure copy
// - bit 3 records instruction access (1) or data access (0)
// - bit 2 records privileged (1) or unprivileged (0)
// - bit 1 records write (1) or read (0)
// - bit 0 marks nested context faults; reserved in the secure copy
// - bits 31:16 and 7 reserved; bits 15:8 implementation-specific storage
// - second syndrome goes to the copy chosen by faulting transaction security
// - bits 30:16 hold descriptor index; unimplemented bits read zero
// - non-secure index readable only through secure alias; non-secure sees zero
// - bits 14:0 hold stream identifier; bits 31 and 15 reserved
// - third syndrome register is a 32-bit implementation-defined word
// - fault status bits clear on writing one, writing zero keeps them
//
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "gfs_defines.vh"

module gfs_syndrome_regs #(
  parameter SECURE_IMPL = 1
) (
  input wire i_clk,
  input wire i_resetn,
  // ahb-lite slave
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  input wire i_hnonsec,
  output wire [31:0] o_hrdata,
  output wire o_hreadyout,
  output wire o_hresp,
  // fault report from the translation unit, same clock
  input wire i_fault_valid,
  input wire [2:0] i_fault_type,
  input wire i_fault_nonsec_attr,
  input wire i_fault_nonsec_state,
  input wire i_fault_instr,
  input wire i_fault_priv,
  input wire i_fault_write,
  input wire i_fault_nested,
  input wire i_fault_xlate_op,
  input wire i_fault_secure_res,
  input wire [7:0] i_fault_impl,
  input wire [14:0] i_fault_sid,
  input wire [14:0] i_fault_ssd,
  input wire [31:0] i_fault_syn2,
  // interrupt
  output wire o_irq
);

  // register state, one copy per security bank for syndromes and status; control and interrupt registers are single
  reg [31:0] syn0_ns_reg;
  reg [31:0] syn0_s_reg;
  reg [31:0] syn1_ns_reg;
  reg [31:0] syn1_s_reg;
  reg [31:0] syn2_ns_reg;
  reg [31:0] syn2_s_reg;
  reg [31:0] fstat_ns_reg;
  reg [31:0] fstat_s_reg;
  reg [31:0] sctrl_reg;
  reg [31:0] irq_sts_reg;
  reg [31:0] irq_mask_reg;
  reg [31:0] syn0_ns_next;
  reg [31:0] syn0_s_next;
  reg [31:0] syn1_ns_next;
  reg [31:0] syn1_s_next;
  reg [31:0] syn2_ns_next;
  reg [31:0] syn2_s_next;
  reg [31:0] fstat_ns_next;
  reg [31:0] fstat_s_next;
  reg [31:0] sctrl_next;
  reg [31:0] irq_sts_next;
  reg [31:0] irq_mask_next;

  // bus pipeline state
  reg wr_pend_reg;
  reg [5:0] wr_addr_reg;
  reg wr_ns_reg;
  reg rd_pend_reg;
  reg [5:0] rd_addr_reg;
  reg rd_ns_reg;
  reg [31:0] hrdata_reg;
  reg [31:0] hrdata_next;
  reg hreadyout_reg;
  reg irq_reg;

  wire addr_take;
  wire secure_acc_wr;
  wire fault_to_secure;
  wire [31:0] fault_type_bit;
  wire [31:0] cap_syn0;
  wire [31:0] cap_syn1;
  wire fault_ns_state;

  // working values of the combinational update
  reg [31:0] clr_ns;
  reg [31:0] clr_s;
  reg load_ns;
  reg load_s;

  // a transfer is taken when selected, non-idle and the bus is ready
  assign addr_take = i_hsel & i_htrans[1] & i_hready;

  // secure banking only exists when the secure option is built
  assign secure_acc_wr = (SECURE_IMPL != 0) & ~wr_ns_reg;

  // bank choice for the faulting transaction: secure-state faults, plus the two
  // cases where a non-secure client fault is reported on the secure side
  assign fault_to_secure = (SECURE_IMPL != 0) &
    (~i_fault_nonsec_state |
     ((i_fault_type == `GFS_FTYPE_CFG_ACCESS) & i_fault_secure_res) |
     ((i_fault_type == `GFS_FTYPE_EXTERNAL) & sctrl_reg[`GFS_SCTRL_EXT_REPORT]));

  // a non-secure access hitting a secure-only place is non-secure by nature,
  // so the state bit is forced even if the source reports it wrongly
  assign fault_ns_state = i_fault_nonsec_state |
    ((i_fault_type == `GFS_FTYPE_CFG_ACCESS) & i_fault_secure_res);

  // one-hot status bit for the reported fault type
  assign fault_type_bit = 32'h00000001 << i_fault_type;

  // captured first syndrome word before the per-copy reserved mask
  assign cap_syn0 = {16'h0000,
                     i_fault_impl,
                     1'b0,
                     i_fault_xlate_op,
                     i_fault_nonsec_attr,
                     fault_ns_state,
                     i_fault_instr,
                     i_fault_priv,
                     i_fault_write,
                     i_fault_nested};

  // captured second syndrome word, narrowed to the implemented index widths
  assign cap_syn1 = {1'b0,
                     {(15 - `GFS_SSD_W){1'b0}}, i_fault_ssd[`GFS_SSD_W-1:0],
                     1'b0,
                     {(15 - `GFS_SID_W){1'b0}}, i_fault_sid[`GFS_SID_W-1:0]};

  // read mux: the access security picks the banked copy, the alias window is
  // secure-only and shows the non-secure copy including the descriptor index
  function [31:0] gfs_read;
    input [5:0] addr;
    input acc_ns;
    input [31:0] s0n;
    input [31:0] s0s;
    input [31:0] s1n;
    input [31:0] s1s;
    input [31:0] s2n;
    input [31:0] s2s;
    input [31:0] fsn;
    input [31:0] fss;
    input [31:0] sct;
    input [31:0] ists;
    input [31:0] imsk;
    reg sec;
    begin
      sec = (SECURE_IMPL != 0) & ~acc_ns;
      gfs_read = `GFS_RESET_WORD;
      if (addr == `GFS_OFF_SYN0) begin
        gfs_read = sec ? s0s : s0n;
      end else if (addr == `GFS_OFF_SYN1) begin
        // non-secure view hides the descriptor index
        gfs_read = sec ? s1s : (s1n & ~`GFS_SYN1_SSD_MASK);
      end else if (addr == `GFS_OFF_SYN2) begin
        gfs_read = sec ? s2s : s2n;
      end else if (addr == `GFS_OFF_FSTAT) begin
        gfs_read = sec ? fss : fsn;
      end else if (addr == `GFS_OFF_ALIAS_SYN0) begin
        gfs_read = sec ? s0n : `GFS_RESET_WORD;
      end else if (addr == `GFS_OFF_ALIAS_SYN1) begin
        gfs_read = sec ? s1n : `GFS_RESET_WORD;
      end else if (addr == `GFS_OFF_ALIAS_SYN2) begin
        gfs_read = sec ? s2n : `GFS_RESET_WORD;
      end else if (addr == `GFS_OFF_ALIAS_FSTAT) begin
        gfs_read = sec ? fsn : `GFS_RESET_WORD;
      end else if (addr == `GFS_OFF_SCTRL) begin
        gfs_read = sec ? sct : `GFS_RESET_WORD;
      end else if (addr == `GFS_OFF_IRQ_STS) begin
        gfs_read = ists;
      end else if (addr == `GFS_OFF_IRQ_MASK) begin
        gfs_read = imsk;
      end
    end
  endfunction

  // next state of every register: software writes first, then hardware events,
  // so a fault in the same cycle as a write or a clear wins, except that one finding status set leaves a syndrome write in place
  always @* begin
    syn0_ns_next = syn0_ns_reg;
    syn0_s_next = syn0_s_reg;
    syn1_ns_next = syn1_ns_reg;
    syn1_s_next = syn1_s_reg;
    syn2_ns_next = syn2_ns_reg;
    syn2_s_next = syn2_s_reg;
    sctrl_next = sctrl_reg;
    irq_mask_next = irq_mask_reg;
    clr_ns = 32'h00000000;
    clr_s = 32'h00000000;
    irq_sts_next = irq_sts_reg;
    load_ns = 1'b0;
    load_s = 1'b0;
    // software write in the data phase
    if (wr_pend_reg) begin
      if (wr_addr_reg == `GFS_OFF_SYN0) begin
        if (secure_acc_wr) begin
          syn0_s_next = i_hwdata & `GFS_SYN0_S_MASK;
        end else begin
          syn0_ns_next = i_hwdata & `GFS_SYN0_NS_MASK;
        end
      end else if (wr_addr_reg == `GFS_OFF_SYN1) begin
        if (secure_acc_wr) begin
          syn1_s_next = i_hwdata & `GFS_SYN1_MASK;
        end else begin
          // index field keeps its value on non-secure writes
          syn1_ns_next = (i_hwdata & `GFS_SYN1_MASK & ~`GFS_SYN1_SSD_MASK) |
                         (syn1_ns_reg & `GFS_SYN1_SSD_MASK);
        end
      end else if (wr_addr_reg == `GFS_OFF_SYN2) begin
        if (secure_acc_wr) begin
          syn2_s_next = i_hwdata;
        end else begin
          syn2_ns_next = i_hwdata;
        end
      end else if (wr_addr_reg == `GFS_OFF_FSTAT) begin
        if (secure_acc_wr) begin
          clr_s = i_hwdata & `GFS_FSTAT_S_MASK;
        end else begin
          clr_ns = i_hwdata & `GFS_FSTAT_NS_MASK;
        end
      end else if (secure_acc_wr) begin
        // alias window and control reach software only from the secure side
        if (wr_addr_reg == `GFS_OFF_ALIAS_SYN0) begin
          syn0_ns_next = i_hwdata & `GFS_SYN0_NS_MASK;
        end else if (wr_addr_reg == `GFS_OFF_ALIAS_SYN1) begin
          syn1_ns_next = i_hwdata & `GFS_SYN1_MASK;
        end else if (wr_addr_reg == `GFS_OFF_ALIAS_SYN2) begin
          syn2_ns_next = i_hwdata;
        end else if (wr_addr_reg == `GFS_OFF_ALIAS_FSTAT) begin
          clr_ns = i_hwdata & `GFS_FSTAT_NS_MASK;
        end else if (wr_addr_reg == `GFS_OFF_SCTRL) begin
          sctrl_next = i_hwdata & `GFS_SCTRL_MASK;
        end
      end
      if (wr_addr_reg == `GFS_OFF_IRQ_STS) begin
        irq_sts_next = irq_sts_reg & ~(i_hwdata & `GFS_IRQ_MASK_BITS);
      end else if (wr_addr_reg == `GFS_OFF_IRQ_MASK) begin
        irq_mask_next = i_hwdata & `GFS_IRQ_MASK_BITS;
      end
    end
    // clearing writes one to a bit, zero leaves it
    fstat_ns_next = fstat_ns_reg & ~clr_ns;
    fstat_s_next = fstat_s_reg & ~clr_s;
    // fault report: first fault loads the syndrome, a later one only adds its type bit and sets multi
    if (i_fault_valid) begin
      if (fault_to_secure) begin
        load_s = ~|fstat_s_next;
        fstat_s_next = fstat_s_next | (fault_type_bit & `GFS_FSTAT_S_MASK);
        if (!load_s) begin
          fstat_s_next[`GFS_FSTAT_MULTI] = 1'b1;
        end
        irq_sts_next[`GFS_IRQ_S_FAULT] = 1'b1;
      end else begin
        load_ns = ~|fstat_ns_next;
        fstat_ns_next = fstat_ns_next | (fault_type_bit & `GFS_FSTAT_NS_MASK);
        if (!load_ns) begin
          fstat_ns_next[`GFS_FSTAT_MULTI] = 1'b1;
        end
        irq_sts_next[`GFS_IRQ_NS_FAULT] = 1'b1;
      end
    end
    // syndrome loads together with the status bit it describes; type 7 in the non-secure copy sets no status bit
    if (load_s) begin
      syn0_s_next = cap_syn0 & `GFS_SYN0_S_MASK;
      syn1_s_next = cap_syn1 & `GFS_SYN1_MASK;
      syn2_s_next = i_fault_syn2;
    end
    if (load_ns) begin
      syn0_ns_next = cap_syn0 & `GFS_SYN0_NS_MASK;
      syn1_ns_next = cap_syn1 & `GFS_SYN1_MASK;
      syn2_ns_next = i_fault_syn2;
    end
  end

  // read data is formed in the wait cycle, after any preceding write has landed
  always @* begin
    hrdata_next = gfs_read(rd_addr_reg, rd_ns_reg, syn0_ns_reg, syn0_s_reg, syn1_ns_reg,
                           syn1_s_reg, syn2_ns_reg, syn2_s_reg, fstat_ns_reg, fstat_s_reg,
                           sctrl_reg, irq_sts_reg, irq_mask_reg);
  end

  // register bank flip-flops
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      syn0_ns_reg <= `GFS_RESET_WORD;
      syn0_s_reg <= `GFS_RESET_WORD;
      syn1_ns_reg <= `GFS_RESET_WORD;
      syn1_s_reg <= `GFS_RESET_WORD;
      syn2_ns_reg <= `GFS_RESET_WORD;
      syn2_s_reg <= `GFS_RESET_WORD;
      fstat_ns_reg <= `GFS_RESET_WORD;
      fstat_s_reg <= `GFS_RESET_WORD;
      sctrl_reg <= `GFS_RESET_WORD;
      irq_sts_reg <= `GFS_RESET_WORD;
      irq_mask_reg <= `GFS_RESET_WORD;
    end else begin
      syn0_ns_reg <= syn0_ns_next;
      syn0_s_reg <= syn0_s_next;
      syn1_ns_reg <= syn1_ns_next;
      syn1_s_reg <= syn1_s_next;
      syn2_ns_reg <= syn2_ns_next;
      syn2_s_reg <= syn2_s_next;
      fstat_ns_reg <= fstat_ns_next;
      fstat_s_reg <= fstat_s_next;
      sctrl_reg <= sctrl_next;
      irq_sts_reg <= irq_sts_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // bus pipeline: writes take no wait state, reads take one so the output
  // can come from a flop without a read-after-write bypass
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 6'h00;
      wr_ns_reg <= 1'b1;
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= 6'h00;
      rd_ns_reg <= 1'b1;
      hrdata_reg <= `GFS_RESET_WORD;
      hreadyout_reg <= 1'b1;
    end else begin
      wr_pend_reg <= addr_take & i_hwrite;
      rd_pend_reg <= addr_take & ~i_hwrite;
      if (addr_take) begin
        // only the low word address bits decode; upper bits alias the bank
        wr_addr_reg <= {i_haddr[5:2], 2'b00};
        rd_addr_reg <= {i_haddr[5:2], 2'b00};
        wr_ns_reg <= i_hnonsec;
        rd_ns_reg <= i_hnonsec;
      end
      hreadyout_reg <= ~(addr_take & ~i_hwrite);
      if (rd_pend_reg) begin
        hrdata_reg <= hrdata_next;
      end
    end
  end

  // level interrupt while any unmasked status bit is set, one cycle behind
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_sts_reg & irq_mask_reg);
    end
  end

  assign o_hrdata = hrdata_reg;
  assign o_hreadyout = hreadyout_reg;
  assign o_hresp = 1'b0; // always okay
  assign o_irq = irq_reg;

endmodule // gfs_syndrome_regs

// ### gfs_defines.vh
// constants of the global fault syndrome register bank: offsets, field positions, masks
// assumes a 32-bit word bus, one aligned word per register, byte addresses below
`ifndef GFS_DEFINES_VH
`define GFS_DEFINES_VH

// register byte offsets, banked window: access security picks the copy
`define GFS_OFF_SYN0 6'h00
`define GFS_OFF_SYN1 6'h04
`define GFS_OFF_SYN2 6'h08
`define GFS_OFF_FSTAT 6'h0C
// secure-only alias window onto the non-secure copies
`define GFS_OFF_ALIAS_SYN0 6'h10
`define GFS_OFF_ALIAS_SYN1 6'h14
`define GFS_OFF_ALIAS_SYN2 6'h18
`define GFS_OFF_ALIAS_FSTAT 6'h1C
// secure configuration, interrupt status and mask
`define GFS_OFF_SCTRL 6'h20
`define GFS_OFF_IRQ_STS 6'h24
`define GFS_OFF_IRQ_MASK 6'h28

// first syndrome register fields
`define GFS_SYN0_NESTED 0
`define GFS_SYN0_WRITE 1
`define GFS_SYN0_PRIV 2
`define GFS_SYN0_INSTR 3
`define GFS_SYN0_NS_STATE 4
`define GFS_SYN0_NS_ATTR 5
`define GFS_SYN0_XLATE_OP 6
`define GFS_SYN0_IMPL_LSB 8
`define GFS_SYN0_IMPL_W 8
// implemented bits of each copy; everything else reads zero and ignores writes
`define GFS_SYN0_NS_MASK 32'h0000FF4F
`define GFS_SYN0_S_MASK 32'h0000FF3E

// second syndrome register fields, implemented index widths
`define GFS_SYN1_SID_LSB 0
`define GFS_SYN1_SSD_LSB 16
`define GFS_SID_W 10
`define GFS_SSD_W 8
`define GFS_SYN1_MASK 32'h00FF03FF
`define GFS_SYN1_SSD_MASK 32'h00FF0000

// fault status: one bit per fault type, plus the multiple-fault bit; the non-secure copy has no bit for type 7
`define GFS_FSTAT_MULTI 31
`define GFS_FSTAT_NS_MASK 32'h8000007F
`define GFS_FSTAT_S_MASK 32'h800000FF
`define GFS_FTYPE_CFG_ACCESS 3'h5
`define GFS_FTYPE_EXTERNAL 3'h6

// secure control bits
`define GFS_SCTRL_EXT_REPORT 0
`define GFS_SCTRL_MASK 32'h00000001

// interrupt status bits
`define GFS_IRQ_NS_FAULT 0
`define GFS_IRQ_S_FAULT 1
`define GFS_IRQ_MASK_BITS 32'h00000003

// reset values
`define GFS_RESET_WORD 32'h00000000

`endif

// ### gfs_syndrome_regs_chk.sv
// checker for the syndrome bank: bus answer timing, zero views, interrupt cause
// assumes hready is looped back from hreadyout and a single clock domain
`timescale 1ns/1ps
`include "gfs_defines.vh"
module gfs_syndrome_regs_chk (
  input wire i_clk,
  input wire i_resetn,
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire i_hready,
  input wire i_hnonsec,
  input wire i_fault_valid,
  input wire [31:0] o_hrdata,
  input wire o_hreadyout,
  input wire o_hresp,
  input wire o_irq
);
  // accepted address phases
  wire rd_go = i_hsel && i_htrans[1] && i_hready && !i_hwrite;
  wire wr_go = i_hsel && i_htrans[1] && i_hready && i_hwrite;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_resp_okay: assert property (o_hresp == 1'b0)
    else $error("response is not okay");
  a_write_no_wait: assert property (wr_go |=> o_hreadyout)
    else $error("write data phase stalled");
  a_read_one_wait: assert property (rd_go |=> !o_hreadyout ##1 o_hreadyout)
    else $error("read wait state count wrong");
  // read data may only move while a read is under way
  a_rdata_hold: assert property ($changed(o_hrdata) |-> $past(rd_go) || $past(rd_go, 2))
    else $error("read data moved without a read");
  // a fault lands in two cycles, a mask write in three
  a_irq_cause: assert property ($rose(o_irq) |-> $past(i_fault_valid, 2) || $past(wr_go, 3))
    else $error("interrupt rose without a cause");
  a_ns_alias_zero: assert property (rd_go && i_hnonsec && i_haddr[5:2] >= 4'h4 &&
    i_haddr[5:2] <= 4'h8 |-> ##2 o_hrdata == 32'h0)
    else $error("non-secure read of secure place not zero");
  a_ns_index_zero: assert property (rd_go && i_hnonsec && i_haddr[5:2] == 4'h1 |->
    ##2 (o_hrdata & `GFS_SYN1_SSD_MASK) == 32'h0)
    else $error("non-secure view shows descriptor index");
  a_syn0_resv: assert property (rd_go && i_haddr[5:2] == 4'h0 |->
    ##2 (o_hrdata & ~($past(i_hnonsec, 2) ? `GFS_SYN0_NS_MASK : `GFS_SYN0_S_MASK)) == 32'h0)
    else $error("reserved first syndrome bit set");
  a_syn1_resv: assert property (rd_go && (i_haddr[5:2] == 4'h1 || i_haddr[5:2] == 4'h5) |->
    ##2 (o_hrdata & ~`GFS_SYN1_MASK) == 32'h0)
    else $error("reserved second syndrome bit set");
  c_read: cover property (rd_go);
  c_write: cover property (wr_go);
  c_irq: cover property ($rose(o_irq));
endmodule // gfs_syndrome_regs_chk

bind gfs_syndrome_regs gfs_syndrome_regs_chk chk_u (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
  .i_hready(i_hready), .i_hnonsec(i_hnonsec), .i_fault_valid(i_fault_valid),
  .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_irq(o_irq));

// ### tb_global_fault_syndrome_regs.sv
// self-checking bench: ahb-lite master tasks, fault pulses, register model
// assumes the bank is the only slave, hready looped back from hreadyout
`timescale 1ns/1ps
`include "gfs_defines.vh"
module tb_global_fault_syndrome_regs;
  reg i_clk = 1'b0, i_resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hns = 1'b0;
  reg fv = 1'b0, fsr = 1'b0;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0, f2 = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg [2:0] fty = 3'h0;
  reg [6:0] fa = 7'h0;
  reg [7:0] fim = 8'h0;
  reg [14:0] fsid = 15'h0, fssd = 15'h0;
  wire [31:0] hrdata;
  wire hready, hresp, irq;
  // model state: index 1 is the non-secure copy, 0 the secure copy
  reg [31:0] e0 [0:1], e1 [0:1], e2 [0:1], fs [0:1];
  reg [31:0] ctl = 32'h0, ists = 32'h0, imsk = 32'h0;
  integer err_count = 0, check_count = 0, cyc = 0, i;

  gfs_syndrome_regs dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hready), .i_hnonsec(hns), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_fault_valid(fv), .i_fault_type(fty),
    .i_fault_nonsec_attr(fa[5]), .i_fault_nonsec_state(fa[4]), .i_fault_instr(fa[3]),
    .i_fault_priv(fa[2]), .i_fault_write(fa[1]), .i_fault_nested(fa[0]),
    .i_fault_xlate_op(fa[6]), .i_fault_secure_res(fsr), .i_fault_impl(fim),
    .i_fault_sid(fsid), .i_fault_ssd(fssd), .i_fault_syn2(f2), .o_irq(irq));

  always #25 i_clk = ~i_clk;
  // hang guard, generous against roughly 12.5k cycles of traffic
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count = err_count + 1;
      test_done;
    end
  end

  task test_done;
    begin
      $display("mismatches %0d comparisons %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  task cmp(input [31:0] g, input [31:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
    end
  endtask

  function [31:0] m0(input ns);
    m0 = ns ? `GFS_SYN0_NS_MASK : `GFS_SYN0_S_MASK;
  endfunction
  function [31:0] mf(input ns);
    mf = ns ? `GFS_FSTAT_NS_MASK : `GFS_FSTAT_S_MASK;
  endfunction

  // expected read value; non-secure sees zero in the alias and secure-only places
  function [31:0] exp_rd(input [3:0] ix, input ns);
    case (ix)
      4'h0: exp_rd = e0[ns];
      4'h1: exp_rd = ns ? e1[1] & ~`GFS_SYN1_SSD_MASK : e1[0];
      4'h2: exp_rd = e2[ns];
      4'h3: exp_rd = fs[ns];
      4'h4: exp_rd = ns ? 32'h0 : e0[1];
      4'h5: exp_rd = ns ? 32'h0 : e1[1];
      4'h6: exp_rd = ns ? 32'h0 : e2[1];
      4'h7: exp_rd = ns ? 32'h0 : fs[1];
      4'h8: exp_rd = ns ? 32'h0 : ctl;
      4'h9: exp_rd = ists;
      4'hA: exp_rd = imsk;
      default: exp_rd = 32'h0;
    endcase
  endfunction

  // one single transfer; request held until hready is seen high
  task ahb(input [3:0] ix, input w, input ns, input [31:0] d, output [31:0] q);
    begin
      @(posedge i_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {26'h0, ix, 2'h0};
      hwrite <= w;
      hns <= ns;
      @(posedge i_clk);
      while (hready !== 1'b1) @(posedge i_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge i_clk);
      while (hready !== 1'b1) @(posedge i_clk);
      q = hrdata;
    end
  endtask

  task wr(input [3:0] ix, input ns, input [31:0] d);
    reg [31:0] q;
    begin
      ahb(ix, 1'b1, ns, d, q);
      case (ix)
        4'h0: e0[ns] = d & m0(ns);
        4'h1: e1[ns] = ns ? (d & `GFS_SYN1_MASK & ~`GFS_SYN1_SSD_MASK) |
          (e1[1] & `GFS_SYN1_SSD_MASK) : d & `GFS_SYN1_MASK;
        4'h2: e2[ns] = d;
        4'h3: fs[ns] = fs[ns] & ~(d & mf(ns));
        4'h4: if (!ns) e0[1] = d & m0(1'b1);
        4'h5: if (!ns) e1[1] = d & `GFS_SYN1_MASK;
        4'h6: if (!ns) e2[1] = d;
        4'h7: if (!ns) fs[1] = fs[1] & ~(d & mf(1'b1));
        4'h8: if (!ns) ctl = d & `GFS_SCTRL_MASK;
        4'h9: ists = ists & ~(d & `GFS_IRQ_MASK_BITS);
        4'hA: imsk = d & `GFS_IRQ_MASK_BITS;
        default: ;
      endcase
    end
  endtask

  // read every place in both security views, then the interrupt level
  task vfy;
    reg [31:0] q;
    integer k;
    begin
      for (k = 0; k < 24; k = k + 1) begin
        ahb(k[4:1], 1'b0, k[0], 32'h0, q);
        cmp(q, exp_rd(k[4:1], k[0]));
      end
      cmp({31'h0, irq}, {31'h0, |(ists & imsk)});
      cmp({31'h0, hresp}, 32'h0);
    end
  endtask

  // one fault pulse; a status already set keeps its syndrome and marks multi
  task flt(input [2:0] ty, input nsst, input sr);
    reg [31:0] x, y;
    reg [14:0] z;
    reg b;
    begin
      x = $urandom;
      y = $urandom;
      z = $urandom;
      @(posedge i_clk);
      fv <= 1'b1;
      fty <= ty;
      fsr <= sr;
      fa <= {x[6:5], nsst, x[3:0]};
      fim <= x[15:8];
      fsid <= x[30:16];
      fssd <= z;
      f2 <= y;
      @(posedge i_clk);
      fv <= 1'b0;
      b = nsst && !(ty == 3'h5 && sr) && !(ty == 3'h6 && ctl[0]);
      if (fs[b] === 32'h0) begin
        e0[b] = {16'h0, x[15:8], 1'b0, x[6:5], nsst | (ty == 3'h5 && sr), x[3:0]} & m0(b);
        e1[b] = {8'h0, z[7:0], 6'h0, x[25:16]};
        e2[b] = y;
      end else fs[b][31] = 1'b1;
      fs[b] = fs[b] | ((32'h1 << ty) & mf(b));
      ists[!b] = 1'b1;
      repeat (2) @(posedge i_clk);
    end
  endtask

  initial begin
    void'($urandom(77442));
    for (i = 0; i < 2; i = i + 1) begin
      e0[i] = 32'h0;
      e1[i] = 32'h0;
      e2[i] = 32'h0;
      fs[i] = 32'h0;
    end
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    vfy;
    // random writes to every place in both views, unmapped one included
    for (i = 0; i < 24; i = i + 1) begin
      wr(i[4:1], i[0], $urandom);
      vfy;
    end
    // every fault type against both routes, control bit and secure-resource flag
    for (i = 0; i < 32; i = i + 1) begin
      wr(4'h8, 1'b0, {31'h0, i[4]});
      wr(4'hA, 1'b0, $urandom);
      flt(i[2:0], i[3], i[4]);
      vfy;
      flt(i[2:0], i[3], i[4]);
      vfy;
      wr(4'h3, 1'b1, 32'hFFFFFFFF);
      wr(4'h3, 1'b0, 32'hFFFFFFFF);
      wr(4'h9, 1'b0, 32'hFFFFFFFF);
      vfy;
    end
    test_done;
  end
endmodule // tb_global_fault_syndrome_regs
